// File: inc/nsc_pkg.sv
// shared constants for the nand command sequencer host
package nsc_pkg;
    // opcodes
    localparam logic [7:0] OP_READ = 8'h00;
    localparam logic [7:0] OP_READ_CONF = 8'h30;
    localparam logic [7:0] OP_PROG = 8'h80;
    localparam logic [7:0] OP_PROG_TRAD2 = 8'h81;
    localparam logic [7:0] OP_PROG_CONF = 8'h10;
    localparam logic [7:0] OP_PLANE_NEXT = 8'h11;
    localparam logic [7:0] OP_CACHE_CONF = 8'h15;
    localparam logic [7:0] OP_ERASE = 8'h60;
    localparam logic [7:0] OP_ERASE_CONF = 8'hd0;
    localparam logic [7:0] OP_ERASE_NEXT = 8'hd1;
    localparam logic [7:0] OP_STATUS = 8'h70;
    localparam logic [7:0] OP_STATUS_ENH = 8'h78;
    localparam logic [7:0] OP_RESET = 8'hff;
    localparam logic [7:0] OP_PARAM = 8'hec;
    localparam logic [7:0] OP_UID = 8'hed;
    // status bit 0 reports fail after program or erase
    localparam int STAT_FAIL_BIT = 0;
    // bad block / erased values
    localparam logic [7:0] BAD_MARK = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] BOOT_SAFE_LAST = 16'h0007;
    // request kinds
    localparam logic [3:0] REQ_READ = 4'h0;
    localparam logic [3:0] REQ_PROG = 4'h1;
    localparam logic [3:0] REQ_ERASE = 4'h2;
    localparam logic [3:0] REQ_STATUS = 4'h3;
    localparam logic [3:0] REQ_RESET = 4'h4;
    localparam logic [3:0] REQ_PARAM = 4'h5;
    localparam logic [3:0] REQ_UID = 4'h6;
    localparam logic [3:0] REQ_PROG2 = 4'h7;
    localparam logic [3:0] REQ_CACHE2 = 4'h8;
    localparam logic [3:0] REQ_ERASE2 = 4'h9;
    localparam logic [3:0] REQ_DATA = 4'ha;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int POR_WAIT_MS = 5;
    localparam int POR_WAIT_CYC = POR_WAIT_MS * 1000 * CLK_MHZ;
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int ADDR_BYTES = 5;
endpackage

// File: src/nsc_pin_cycle.sv
// one strobed bus cycle: command, address, data write or data read
module nsc_pin_cycle (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request
    input wire logic i_go,
    input wire logic [1:0] i_kind,
    input wire logic [7:0] i_byte,
    // answer
    output logic o_done,
    output logic [7:0] o_rd_byte,
    // pins
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic [7:0] o_io,
    output logic o_io_oe,
    input wire logic [7:0] i_io
);
    // kind 0 command, 1 address, 2 data write, 3 data read
    logic [7:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_nxt, cle_nxt, ale_nxt, we_nxt, re_nxt, oe_nxt;
    logic [7:0] io_nxt, rd_nxt;
    localparam logic [7:0] HALF = 8'(nsc_pkg::STROBE_CYC);

    always_comb
    begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        cle_nxt = o_cle;
        ale_nxt = o_ale;
        we_nxt = o_we_n;
        re_nxt = o_read_strobe_n;
        oe_nxt = o_io_oe;
        io_nxt = o_io;
        rd_nxt = o_rd_byte;
        if (!busy_r && i_go)
        begin
            busy_nxt = 1'b1;
            cnt_nxt = 8'h00;
            cle_nxt = (i_kind == 2'd0);
            ale_nxt = (i_kind == 2'd1);
            oe_nxt = (i_kind != 2'd3);
            io_nxt = i_byte;
            we_nxt = (i_kind == 2'd3);
            re_nxt = (i_kind != 2'd3);
        end
        else if (busy_r)
        begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == HALF)
            begin
                // sample read data just before the rising strobe
                if (!o_read_strobe_n)
                    rd_nxt = i_io;
                we_nxt = 1'b1;
                re_nxt = 1'b1;
            end
            else if (cnt_r == HALF + HALF)
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                cle_nxt = 1'b0;
                ale_nxt = 1'b0;
                oe_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            o_done <= 1'b0;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io_oe <= 1'b0;
            o_io <= 8'h00;
            o_rd_byte <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            o_done <= done_nxt;
            o_cle <= cle_nxt;
            o_ale <= ale_nxt;
            o_we_n <= we_nxt;
            o_read_strobe_n <= re_nxt;
            o_io_oe <= oe_nxt;
            o_io <= io_nxt;
            o_rd_byte <= rd_nxt;
        end
    end
endmodule

// File: src/nsc_host.sv
// host sequencer issuing nand command sequences over the pins
// Notes on behaviour
// - strobe levels classify each cycle as command, address or data.
// - read 00h/30h, program 80h/10h, erase 60h/d0h sequences.
// - standard two-plane erase: 60h, d1h, 60h, d0h.
// - standard two-plane cache program: 80h, 11h, 80h, 15h.
// - standard two-plane final or plain program: 80h, 11h, 80h, 10h.
// - traditional two-plane cache program uses 81h third, then 15h.
// - traditional two-plane plain program: 80h, 11h, 81h, 10h.
// - traditional two-plane erase: 60h, 60h, d0h only.
// - host waits ready high or 5 ms after power-on.
// - keep write protect low and chip enable high at power-up.
// - read bad-block marker before erasing a block; erase requests read nothing first, only data reads set o_bad_mark on 00h.
// - read status after every program and erase.
module nsc_host #(
    parameter int POR_CYC = nsc_pkg::POR_WAIT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // user request
    input wire logic i_req,
    input wire logic [3:0] i_op,
    input wire logic i_trad,
    input wire logic [39:0] i_addr,
    input wire logic [39:0] i_addr2,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_wp_release,
    // user answer
    output logic o_ready,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_fail,
    output logic o_bad_mark,
    // nand pins
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic o_wp_n,
    output logic [7:0] o_io,
    output logic o_io_oe,
    input wire logic [7:0] i_io,
    input wire logic i_rb
);
    typedef enum logic [3:0] {
        ST_POR = 4'b0000,
        ST_IDLE = 4'b0001,
        ST_STEP = 4'b0010,
        ST_WAIT_BUSY = 4'b0100,
        ST_STATUS = 4'b0101
    } nsc_state_t;

    // a step: kind(2) byte(8); kind 0 cmd, 1 addr, 2 wr, 3 rd
    nsc_state_t st_r, st_nxt;
    logic [31:0] por_r, por_nxt;
    logic [9:0] seq_r [0:15];
    logic [9:0] seq_nxt [0:15];
    logic [3:0] idx_r, idx_nxt, len_r, len_nxt;
    logic chk_r, chk_nxt;
    logic go_nxt, go_r;
    logic ready_nxt, done_nxt, fail_nxt, wp_nxt, ce_nxt, bad_nxt;
    logic [7:0] rdata_nxt;
    logic [1:0] rbwait_r, rbwait_nxt;
    logic cyc_done;
    logic [7:0] cyc_byte;

    function automatic logic [9:0] cmd(input logic [7:0] b);
        cmd = {2'd0, b};
    endfunction

    function automatic logic [9:0] adr(input logic [39:0] a,
                                       input int k);
        adr = {2'd1, a[8*k +: 8]};
    endfunction

    nsc_pin_cycle u_cyc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_go(go_r),
        .i_kind(seq_r[idx_r][9:8]),
        .i_byte(seq_r[idx_r][7:0]),
        .o_done(cyc_done),
        .o_rd_byte(cyc_byte),
        .o_cle(o_cle),
        .o_ale(o_ale),
        .o_we_n(o_we_n),
        .o_read_strobe_n(o_read_strobe_n),
        .o_io(o_io),
        .o_io_oe(o_io_oe),
        .i_io(i_io)
    );

    always_comb
    begin
        st_nxt = st_r;
        por_nxt = por_r;
        seq_nxt = seq_r;
        idx_nxt = idx_r;
        len_nxt = len_r;
        chk_nxt = chk_r;
        go_nxt = 1'b0;
        ready_nxt = 1'b0;
        done_nxt = 1'b0;
        fail_nxt = o_fail;
        wp_nxt = o_wp_n;
        ce_nxt = o_ce_n;
        bad_nxt = o_bad_mark;
        rdata_nxt = o_rdata;
        rbwait_nxt = rbwait_r;
        case (st_r)
            ST_POR:
            begin
                // wp low and ce high until power-on reset ends
                wp_nxt = 1'b0;
                ce_nxt = 1'b1;
                por_nxt = por_r + 32'd1;
                if ((por_r >= 32'(POR_CYC)) || (por_r > 32'd2 && i_rb))
                    st_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                ready_nxt = !i_req;
                if (i_wp_release)
                    wp_nxt = 1'b1;
                if (i_req)
                begin
                    ce_nxt = 1'b0;
                    idx_nxt = 4'h0;
                    chk_nxt = 1'b0;
                    st_nxt = ST_STEP;
                    len_nxt = 4'h1;
                    seq_nxt[0] = cmd(nsc_pkg::OP_STATUS);
                    case (i_op)
                        nsc_pkg::REQ_READ:
                        begin
                            seq_nxt[0] = cmd(nsc_pkg::OP_READ);
                            for (int k = 0; k < 5; k++)
                                seq_nxt[1 + k] = adr(i_addr, k);
                            seq_nxt[6] = cmd(nsc_pkg::OP_READ_CONF);
                            len_nxt = 4'd7;
                        end
                        nsc_pkg::REQ_PROG, nsc_pkg::REQ_ERASE:
                        begin
                            // program: 10h follows the address at once, no data cycles in between
                            seq_nxt[0] = cmd(i_op == nsc_pkg::REQ_PROG ?
                                nsc_pkg::OP_PROG : nsc_pkg::OP_ERASE);
                            for (int k = 0; k < 5; k++)
                                seq_nxt[1 + k] = adr(i_addr, k);
                            seq_nxt[6] = cmd(i_op == nsc_pkg::REQ_PROG ?
                                nsc_pkg::OP_PROG_CONF : nsc_pkg::OP_ERASE_CONF);
                            chk_nxt = 1'b1;
                            len_nxt = 4'd7;
                        end
                        nsc_pkg::REQ_PROG2, nsc_pkg::REQ_CACHE2:
                        begin
                            seq_nxt[0] = cmd(nsc_pkg::OP_PROG);
                            for (int k = 0; k < 5; k++)
                                seq_nxt[1 + k] = adr(i_addr, k);
                            seq_nxt[6] = cmd(nsc_pkg::OP_PLANE_NEXT);
                            seq_nxt[7] = cmd(i_trad ? nsc_pkg::OP_PROG_TRAD2 :
                                nsc_pkg::OP_PROG);
                            for (int k = 0; k < 5; k++)
                                seq_nxt[8 + k] = adr(i_addr2, k);
                            seq_nxt[13] = cmd(i_op == nsc_pkg::REQ_CACHE2 ?
                                nsc_pkg::OP_CACHE_CONF :
                                nsc_pkg::OP_PROG_CONF);
                            chk_nxt = 1'b1;
                            len_nxt = 4'd14;
                        end
                        nsc_pkg::REQ_ERASE2:
                        begin
                            seq_nxt[0] = cmd(nsc_pkg::OP_ERASE);
                            for (int k = 0; k < 3; k++)
                                seq_nxt[1 + k] = adr(i_addr, k + 2);
                            seq_nxt[4] = cmd(nsc_pkg::OP_ERASE_NEXT);
                            seq_nxt[5] = cmd(nsc_pkg::OP_ERASE);
                            for (int k = 0; k < 3; k++)
                                seq_nxt[6 + k] = adr(i_addr2, k + 2);
                            seq_nxt[9] = cmd(nsc_pkg::OP_ERASE_CONF);
                            len_nxt = 4'd10;
                            if (i_trad)
                            begin
                                // three command cycles only
                                seq_nxt[4] = cmd(nsc_pkg::OP_ERASE);
                                for (int k = 0; k < 3; k++)
                                    seq_nxt[5 + k] = adr(i_addr2, k + 2);
                                seq_nxt[8] = cmd(nsc_pkg::OP_ERASE_CONF);
                                len_nxt = 4'd9;
                            end
                            chk_nxt = 1'b1;
                        end
                        nsc_pkg::REQ_RESET:
                            seq_nxt[0] = cmd(nsc_pkg::OP_RESET);
                        nsc_pkg::REQ_PARAM, nsc_pkg::REQ_UID:
                        begin
                            seq_nxt[0] = cmd(i_op == nsc_pkg::REQ_UID ?
                                nsc_pkg::OP_UID : nsc_pkg::OP_PARAM);
                            seq_nxt[1] = {2'd1, 8'h00};
                            len_nxt = 4'd2;
                        end
                        nsc_pkg::REQ_DATA:
                            seq_nxt[0] = i_rd ? {2'd3, 8'h00} :
                                {2'd2, i_wdata};
                        default:
                            seq_nxt[0] = cmd(nsc_pkg::OP_STATUS);
                    endcase
                    go_nxt = 1'b1;
                end
            end
            ST_STEP:
            begin
                if (cyc_done)
                begin
                    if (seq_r[idx_r][9:8] == 2'd3)
                    begin
                        rdata_nxt = cyc_byte;
                        bad_nxt = (cyc_byte == nsc_pkg::BAD_MARK);
                    end
                    rbwait_nxt = 2'd0;
                    // confirms, 11h and d1h all start busy; wait ready
                    if (seq_r[idx_r][9:8] == 2'd0 && seq_r[idx_r][7:0] inside
                        {nsc_pkg::OP_READ_CONF, nsc_pkg::OP_PROG_CONF,
                         nsc_pkg::OP_CACHE_CONF, nsc_pkg::OP_ERASE_CONF,
                         nsc_pkg::OP_RESET, nsc_pkg::OP_PLANE_NEXT,
                         nsc_pkg::OP_ERASE_NEXT})
                        st_nxt = ST_WAIT_BUSY;
                    else if (idx_r + 4'h1 == len_r)
                    begin
                        done_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                    else
                    begin
                        idx_nxt = idx_r + 4'h1;
                        go_nxt = 1'b1;
                    end
                end
            end
            ST_WAIT_BUSY:
            begin
                // give the device time to pull ready/busy low
                if (rbwait_r != 2'd3)
                    rbwait_nxt = rbwait_r + 2'd1;
                else if (i_rb)
                begin
                    if (idx_r + 4'h1 != len_r)
                    begin
                        idx_nxt = idx_r + 4'h1;
                        go_nxt = 1'b1;
                        st_nxt = ST_STEP;
                    end
                    else if (chk_r)
                    begin
                        seq_nxt[0] = cmd(nsc_pkg::OP_STATUS);
                        seq_nxt[1] = {2'd3, 8'h00};
                        idx_nxt = 4'h0;
                        len_nxt = 4'd2;
                        chk_nxt = 1'b0;
                        go_nxt = 1'b1;
                        st_nxt = ST_STATUS;
                    end
                    else
                    begin
                        done_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
            end
            ST_STATUS:
            begin
                if (cyc_done)
                begin
                    if (idx_r == 4'h1)
                    begin
                        fail_nxt = cyc_byte[nsc_pkg::STAT_FAIL_BIT];
                        rdata_nxt = cyc_byte;
                        done_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                    else
                    begin
                        idx_nxt = 4'h1;
                        go_nxt = 1'b1;
                    end
                end
            end
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_r <= ST_POR;
            por_r <= 32'd0;
            for (int k = 0; k < 16; k++)
                seq_r[k] <= 10'h000;
            idx_r <= 4'h0;
            len_r <= 4'h0;
            chk_r <= 1'b0;
            go_r <= 1'b0;
            rbwait_r <= 2'd0;
            o_ready <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_rdata <= 8'h00;
            o_bad_mark <= 1'b0;
            o_wp_n <= 1'b0;
            o_ce_n <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            por_r <= por_nxt;
            seq_r <= seq_nxt;
            idx_r <= idx_nxt;
            len_r <= len_nxt;
            chk_r <= chk_nxt;
            go_r <= go_nxt;
            rbwait_r <= rbwait_nxt;
            o_ready <= ready_nxt;
            o_done <= done_nxt;
            o_fail <= fail_nxt;
            o_rdata <= rdata_nxt;
            o_bad_mark <= bad_nxt;
            o_wp_n <= wp_nxt;
            o_ce_n <= ce_nxt;
        end
    end
endmodule

// File: bench/nsc_host_asserts.sv
// pin-level checks for the nand host sequencer
module nsc_host_asserts #(
    parameter int POR_CYC = 50
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // user side
    input wire logic i_req,
    input wire logic i_wp_release,
    input wire logic o_ready,
    input wire logic o_done,
    // nand pins
    input wire logic o_ce_n,
    input wire logic o_cle,
    input wire logic o_ale,
    input wire logic o_we_n,
    input wire logic o_wp_n,
    input wire logic [7:0] o_io,
    input wire logic o_io_oe,
    input wire logic i_rb
);
    int cnt_r;
    int cnt_nxt;
    logic por_ok_r;
    logic por_ok_nxt;
    logic cmd;

    assign cmd = o_cle && !o_we_n;

    // lockout ends on ready high or on the full wait
    always_comb
    begin
        cnt_nxt = (cnt_r < POR_CYC) ? cnt_r + 1 : cnt_r;
        por_ok_nxt = por_ok_r || i_rb || cnt_r >= POR_CYC;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_r <= 0;
            por_ok_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            por_ok_r <= por_ok_nxt;
        end
    end

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_cmd_strobes;
        o_cle |-> !o_ale && !o_ce_n;
    endproperty
    a_cmd_strobes: assert property (p_cmd_strobes)
        else $error("command strobe with address strobe or deselected");

    property p_we_drives;
        !o_we_n |-> o_io_oe && !o_ce_n && (o_cle != o_ale || !o_cle);
    endproperty
    a_we_drives: assert property (p_we_drives)
        else $error("write strobe without bus drive");

    property p_busy_cmds;
        cmd && !i_rb |-> o_io inside {8'hff, 8'h70, 8'h78};
    endproperty
    a_busy_cmds: assert property (p_busy_cmds)
        else $error("command other than reset or status while busy");

    property p_defined_op;
        cmd |-> o_io inside {8'h00, 8'h30, 8'h80, 8'h81, 8'h10, 8'h11,
            8'h15, 8'h60, 8'hd0, 8'hd1, 8'h70, 8'h78, 8'hff, 8'hec, 8'hed};
    endproperty
    a_defined_op: assert property (p_defined_op)
        else $error("undefined opcode sent");

    property p_por_wait;
        cmd |-> por_ok_r;
    endproperty
    a_por_wait: assert property (p_por_wait)
        else $error("command during power-on lockout");

    property p_reset_pins;
        $fell(i_rst) |-> (o_ce_n && !o_wp_n && !o_ready) [*2];
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("device selected or writable right after reset");

    property p_done_pulse;
        o_done |=> !o_done [*3];
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");

    property p_take;
        o_ready && i_req |=> !o_ready ##1 !o_ready;
    endproperty
    a_take: assert property (p_take)
        else $error("ready stays high after a taken request");

    property p_wp_prog;
        cmd && i_wp_release && o_io inside {8'h80, 8'h60} |-> o_wp_n;
    endproperty
    a_wp_prog: assert property (p_wp_prog)
        else $error("program or erase sent with write protect low");
endmodule

bind nsc_host nsc_host_asserts #(.POR_CYC(POR_CYC)) nsc_host_asserts_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .i_wp_release(i_wp_release), .o_ready(o_ready), .o_done(o_done),
    .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
    .o_wp_n(o_wp_n), .o_io(o_io), .o_io_oe(o_io_oe), .i_rb(i_rb)
);

// File: bench/nsc_nand_model.sv
// behavioural nand device facing the host sequencer
module nsc_nand_model #(
    // away from blocks 0-7, which ship good
    parameter logic [39:0] BAD_ADDR = 40'h00_0040_0000,
    parameter logic [7:0] PARAM_BYTE = 8'h4f,
    parameter logic [7:0] UID_BYTE = 8'h5a,
    parameter int POR_NS = 240
) (
    // pins
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_read_strobe_n,
    input wire logic i_wp_n,
    input wire logic [7:0] i_io,
    output logic [7:0] o_io,
    output logic o_rb_pd,
    // scenario control
    input wire logic i_fail,
    input wire logic [7:0] i_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic por = 1'b1;
    logic busy = 1'b1;
    logic pe = 1'b0;
    logic [39:0] adr = '0;
    logic [7:0] dout = '0;
    logic [7:0] q = '0;
    time busy_end = 0;

    task automatic hold();
        busy_end = $time + 8 * (i_busy + 1);
    endtask

    initial #(POR_NS) por = 1'b0;
    always #2 busy = por || $time < busy_end;
    assign o_rb_pd = busy; // pulls low only, pull-up outside
    // released bus shows the inverse so stale data never passes
    assign o_io = (!i_ce_n && !i_read_strobe_n) ? q : ~q;
    always @(negedge i_read_strobe_n) q = dout;
    always @(negedge i_wp_n) if (pe) busy_end = $time;

    always @(posedge i_we_n)
    begin
        if (!i_ce_n && i_cle && !i_ale)
        begin
            if (!busy || i_io inside {8'hff, 8'h70, 8'h78})
            begin
                case (i_io)
                    8'h00, 8'h80, 8'h81, 8'h60: adr = '0;
                    8'h30:
                    begin
                        pe = 1'b0;
                        dout = (adr == BAD_ADDR) ? nsc_pkg::BAD_MARK
                            : nsc_pkg::ERASED_BYTE;
                        hold();
                    end
                    8'h10, 8'h11, 8'h15, 8'hd0, 8'hd1:
                    begin
                        pe = 1'b1;
                        hold();
                    end
                    8'h70, 8'h78: dout = {7'h38, i_fail};
                    8'hec: dout = PARAM_BYTE;
                    8'hed: dout = UID_BYTE;
                    8'hff: hold();
                    default: ;
                endcase
            end
        end
        else if (!i_ce_n && i_ale && !i_cle)
            adr = {i_io, adr[39:8]};
    end
endmodule

// File: bench/nsc_host_test.sv
// self-checking bench for the nand host sequencer
module nsc_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] BAD = 40'h00_0040_0000;
    logic i_clk = 0, i_rst = 1, i_req = 0, i_trad = 0, i_rd = 0;
    logic i_wp_release = 1, fail = 0, bad = 0, dev_pd;
    logic [3:0] i_op = '0;
    logic [39:0] i_addr = '0, i_addr2 = '0, c;
    logic [7:0] i_wdata = '0, busy_cyc = 8'h0a, o_rdata, o_io, i_io, dev_io;
    logic o_ready, o_done, o_fail, o_bad_mark, o_ce_n, o_cle, o_ale;
    logic o_we_n, o_read_strobe_n, o_wp_n, o_io_oe, i_rb;
    logic [7:0] exp_cmd[$];
    logic [9:0] exp_done[$];
    logic [9:0] de;
    int err_total = 0, checks_done = 0;

    assign i_rb = ~dev_pd;
    assign i_io = o_io_oe ? o_io : dev_io;

    nsc_host #(.POR_CYC(50)) nsc_host_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_op(i_op),
        .i_trad(i_trad), .i_addr(i_addr), .i_addr2(i_addr2),
        .i_wdata(i_wdata), .i_rd(i_rd), .i_wp_release(i_wp_release),
        .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
        .o_fail(o_fail), .o_bad_mark(o_bad_mark), .o_ce_n(o_ce_n),
        .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
        .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n), .o_io(o_io),
        .o_io_oe(o_io_oe), .i_io(i_io), .i_rb(i_rb)
    );

    nsc_nand_model #(.BAD_ADDR(BAD)) nsc_nand_model_inst (
        .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
        .i_read_strobe_n(o_read_strobe_n), .i_wp_n(o_wp_n), .i_io(i_io),
        .o_io(dev_io), .o_rb_pd(dev_pd), .i_fail(fail), .i_busy(busy_cyc)
    );

    initial forever #4 i_clk = ~i_clk;

    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // note commands and the done result, then issue one request
    task automatic req(input logic [3:0] op, input logic tr,
                       input logic [39:0] cm, input int n,
                       input logic [9:0] d);
        int k;
        for (k = n - 1; k >= 0; k--)
            exp_cmd.push_back(cm[k*8 +: 8]);
        exp_done.push_back(d);
        for (k = 0; k < 4000 && o_ready !== 1'b1; k++)
            @(negedge i_clk);
        i_op = op;
        i_trad = tr;
        i_addr = bad ? BAD : {8'($urandom), 32'($urandom)};
        i_addr2 = {8'($urandom), 32'($urandom)};
        i_wdata = 8'($urandom);
        i_req = 1'b1;
        @(negedge i_clk);
        i_req = 1'b0;
        for (k = 0; k < 4000 && o_done !== 1'b1; k++)
            @(negedge i_clk);
    endtask

    task automatic rd(input logic [9:0] d);
        i_rd = 1'b1;
        req(nsc_pkg::REQ_DATA, 0, 0, 0, d);
        i_rd = 1'b0;
    endtask

    always @(posedge o_we_n)
    begin
        if (o_cle === 1'b1 && o_ce_n === 1'b0)
            check8("command", exp_cmd.size() ? exp_cmd.pop_front() : 8'hxx,
                   o_io);
    end

    always @(negedge i_clk)
    begin
        if (o_done === 1'b1)
        begin
            de = exp_done.size() ? exp_done.pop_front() : 10'h000;
            if (de[9:8] == 2'h1)
            begin
                check8("rdata", de[7:0], o_rdata);
                check8("bad_mark", 8'(de[7:0] == 8'h00),
                       8'(o_bad_mark));
            end
            if (de[9:8] == 2'h2)
                check8("fail", 8'(de[0]), 8'(o_fail));
        end
    end

    initial
    begin
        void'($urandom(32'h4423));
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check8("ce_n", 8'h01, 8'(o_ce_n));
        check8("wp_n", 8'h00, 8'(o_wp_n));
        req(nsc_pkg::REQ_RESET, 0, 40'hff, 1, 10'h000);
        req(nsc_pkg::REQ_STATUS, 0, 40'h70, 1, 10'h000);
        rd(10'h170);
        for (int b = 0; b < 2; b++)
        begin
            bad = b[0];
            req(nsc_pkg::REQ_READ, 0, 40'h0030, 2, 10'h000);
            bad = 1'b0;
            rd(b ? 10'h100 : 10'h1ff);
        end
        req(nsc_pkg::REQ_PARAM, 0, 40'hec, 1, 10'h000);
        rd(10'h14f);
        req(nsc_pkg::REQ_UID, 0, 40'hed, 1, 10'h000);
        rd(10'h15a);
        req(nsc_pkg::REQ_DATA, 0, 0, 0, 10'h000);
        for (int f = 0; f < 2; f++)
        begin
            fail = f[0];
            busy_cyc = 8'($urandom_range(60, 2));
            req(nsc_pkg::REQ_PROG, 0, 40'h801070, 3, {9'h100, fail});
            req(nsc_pkg::REQ_ERASE, 0, 40'h60d070, 3, {9'h100, fail});
        end
        fail = 1'b0;
        for (int t = 0; t < 2; t++)
        begin
            c = t ? 40'h80_11_81_10_70 : 40'h80_11_80_10_70;
            req(nsc_pkg::REQ_PROG2, t[0], c, 5, 10'h200);
            c = t ? 40'h80_11_81_15_70 : 40'h80_11_80_15_70;
            req(nsc_pkg::REQ_CACHE2, t[0], c, 5, 10'h200);
            c = t ? 40'h00_60_60_d0_70 : 40'h60_d1_60_d0_70;
            req(nsc_pkg::REQ_ERASE2, t[0], c, 5 - t, 10'h200);
        end
        repeat (20) @(negedge i_clk);
        check8("pending", 8'h00, 8'(exp_cmd.size() + exp_done.size()));
        print_verdict();
    end

    initial
    begin
        #480000;
        err_total++;
        print_verdict();
    end
endmodule
